// file: uep_consts.vh
// What this block does
// R1: Mask bits for endpoints 1 to 7 gate NAK flags; 0 passes, 1 blocks.
// R2: A masked endpoint still sets its NAK flag but raises no interrupt.
// R3: Zero-length pending sets on the transmit command, clears once that packet is sent.
// R4: Data-present follows the FIFO's valid data; a setup token forces it to zero.
// R5: Seven-bit read/write field holds the endpoint 0 maximum packet size.
// R6: Setup lock sets after a setup token, clears on the setup-acknowledge command.
// R7: While setup lock is set every endpoint 0 FIFO write is discarded.
// R8: Two-bit read-only toggle field: 00 DATA0, 01 DATA1, others reserved.
// R9: Three-bit state field returns to Ready 000 on a setup token; any other state event in that same cycle wins.
// R10: State becomes Busy 001 on a NAK in the status stage.
// R11: State becomes Error 010 on receive CRC failure or timeout after transmit.
// R12: State becomes Stall 011 and STALL is answered on an over-length control read.
// R13: NAK flag of endpoints 1 to 7 sets on every NAK sent; none for endpoint 0.
// R14: Reserved bits are written zero, read zero; every field resets to zero.
`ifndef UEP_CONSTS_VH
`define UEP_CONSTS_VH

// Register byte offsets
`define UEP_OFS_NAK_FLAG 5'h00
`define UEP_OFS_NAK_MASK 5'h04
`define UEP_OFS_EP0_MSZ 5'h08
`define UEP_OFS_EP0_STS 5'h0C
`define UEP_OFS_CMD 5'h10
`define UEP_ADDR_W 5

// Field positions
`define UEP_EP_HI 7
`define UEP_EP_LO 1
`define UEP_MSZ_PKT_HI 6
`define UEP_MSZ_DSET 12
`define UEP_MSZ_ZLP 15
`define UEP_STS_STATE_LO 9
`define UEP_STS_TOG_LO 12
`define UEP_STS_LOCK 15
`define UEP_CMD_ZLP 0
`define UEP_CMD_SETUP_ACK 1

// Reset values
`define UEP_RST_MASK 7'h00
`define UEP_RST_FLAGS 7'h00
`define UEP_RST_PKT 7'h00
`define UEP_RST_STATE 3'h0
`define UEP_RST_TOG 2'h0

// Endpoint 0 state codes
`define UEP_ST_READY 3'h0
`define UEP_ST_BUSY 3'h1
`define UEP_ST_ERROR 3'h2
`define UEP_ST_STALL 3'h3

// Bus responses
`define UEP_RESP_OKAY 2'h0
`define UEP_RESP_DECERR 2'h3

`endif

// file: uep_ep0_status.v
`timescale 1ns/1ps
`include "uep_consts.vh"

module uep_ep0_status (
  // Clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // AXI4-Lite write address
  input wire [4:0] s_axi_awaddr_i,
  input wire [2:0] s_axi_awprot_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  // AXI4-Lite read address
  input wire [4:0] s_axi_araddr_i,
  input wire [2:0] s_axi_arprot_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Packet engine events, one-cycle pulses
  input wire [7:1] nak_sent_i,
  input wire setup_token_i,
  input wire zlp_sent_i,
  input wire status_nak_i,
  input wire rx_crc_err_i,
  input wire tx_timeout_i,
  input wire over_len_read_i,
  // Packet engine levels
  input wire [1:0] ep0_toggle_i,
  input wire fifo_has_data_i,
  // Endpoint 0 FIFO write path from the CPU side
  input wire fifo_wr_i,
  input wire [15:0] fifo_wr_data_i,
  output reg fifo_wr_o,
  output reg [15:0] fifo_wr_data_o,
  // Handshake and interrupt
  output reg stall_req_o,
  output reg zlp_req_o,
  output reg nak_irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Bus slave state

reg aw_got_r;
reg w_got_r;
reg [4:0] aw_addr_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;

wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
wire w_take = s_axi_wvalid_i & s_axi_wready_o;
wire aw_have = aw_got_r | aw_take;
wire w_have = w_got_r | w_take;
wire [4:0] wr_addr = aw_got_r ? aw_addr_r : s_axi_awaddr_i;
wire [31:0] wr_data = w_got_r ? w_data_r : s_axi_wdata_i;
wire [3:0] wr_strb = w_got_r ? w_strb_r : s_axi_wstrb_i;
wire wr_do = aw_have & w_have & ~s_axi_bvalid_o;
wire rd_take = s_axi_arvalid_i & s_axi_arready_o;

// Byte lane 0 carries every writable field
wire wr_lane0 = wr_do & wr_strb[0];

function hit;
  input [4:0] addr;
  input [4:0] ofs;
  begin
    hit = (addr[4:2] == ofs[4:2]);
  end
endfunction

// Five words are mapped; the command word is write-only and reads back zero
function mapped;
  input [4:0] addr;
  begin
    mapped = hit(addr, `UEP_OFS_NAK_FLAG) | hit(addr, `UEP_OFS_NAK_MASK) |
      hit(addr, `UEP_OFS_EP0_MSZ) | hit(addr, `UEP_OFS_EP0_STS) |
      hit(addr, `UEP_OFS_CMD);
  end
endfunction

// One decode serves both channels, so a hole answers alike on write and read
function [1:0] resp_for;
  input [4:0] addr;
  begin
    resp_for = mapped(addr) ? `UEP_RESP_OKAY : `UEP_RESP_DECERR;
  end
endfunction

wire wr_mask = wr_lane0 & hit(wr_addr, `UEP_OFS_NAK_MASK);
wire wr_msz = wr_lane0 & hit(wr_addr, `UEP_OFS_EP0_MSZ);
wire wr_cmd = wr_lane0 & hit(wr_addr, `UEP_OFS_CMD);
// Reading the flag word clears it, so only a taken read may do so
wire rd_flags = rd_take & hit(s_axi_araddr_i, `UEP_OFS_NAK_FLAG);

////////////////////////////////////////////////////////////////////////////////
// NAK flags and mask

reg [7:1] nak_flag_r;
reg [7:1] nak_mask_r;
reg [7:1] nak_flag_nxt;
reg [7:1] nak_mask_nxt;

always @* begin
  // R13: NAK sets flag
  // Read clears, but a NAK in the same cycle wins
  nak_flag_nxt = (nak_flag_r & ~({7{rd_flags}})) | nak_sent_i;
  nak_mask_nxt = nak_mask_r;
  // R14: reserved mask bits ignored
  if (wr_mask) begin
    nak_mask_nxt = wr_data[`UEP_EP_HI:`UEP_EP_LO];
  end
end

// Flags stay sticky until the flag word is read
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    nak_flag_r <= `UEP_RST_FLAGS;
    nak_mask_r <= `UEP_RST_MASK;
  end else begin
    nak_flag_r <= nak_flag_nxt;
    nak_mask_r <= nak_mask_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Endpoint 0 size and status

reg [6:0] max_pkt_r;
reg zlp_pend_r;
reg dset_r;
reg lock_r;
reg [1:0] tog_r;
reg [2:0] state_r;

// Write-only command strobes, one cycle each
wire cmd_zlp = wr_cmd & wr_data[`UEP_CMD_ZLP];
wire cmd_ack = wr_cmd & wr_data[`UEP_CMD_SETUP_ACK];

reg zlp_pend_nxt;
reg lock_nxt;
reg [2:0] state_nxt;

always @* begin
  // R3: zero-length pending
  zlp_pend_nxt = (zlp_pend_r & ~zlp_sent_i) | cmd_zlp;
  // R6: setup lock set wins
  lock_nxt = (lock_r & ~cmd_ack) | setup_token_i;
  state_nxt = state_r;
  // Later tests win: stall over error over busy over ready
  // R9: setup returns Ready
  if (setup_token_i) begin
    state_nxt = `UEP_ST_READY;
  end
  // R10: status-stage NAK
  if (status_nak_i) begin
    state_nxt = `UEP_ST_BUSY;
  end
  // R11: CRC or timeout
  if (rx_crc_err_i | tx_timeout_i) begin
    state_nxt = `UEP_ST_ERROR;
  end
  // R12: over-length read stalls
  if (over_len_read_i) begin
    state_nxt = `UEP_ST_STALL;
  end
end

// The size field is software's own; it is kept apart from the event-driven bits
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    max_pkt_r <= `UEP_RST_PKT;
  end else begin
    // R5: max packet size
    if (wr_msz) begin
      max_pkt_r <= wr_data[`UEP_MSZ_PKT_HI:0];
    end
  end
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    zlp_pend_r <= 1'b0;
    dset_r <= 1'b0;
    lock_r <= 1'b0;
    tog_r <= `UEP_RST_TOG;
    state_r <= `UEP_RST_STATE;
  end else begin
    zlp_pend_r <= zlp_pend_nxt;
    // R4: data present
    // Low for the cycle after a setup token, then the live level again
    dset_r <= fifo_has_data_i & ~setup_token_i;
    lock_r <= lock_nxt;
    // R8: toggle report
    // The toggle belongs to the packet engine; a setup token leaves it alone
    tog_r <= ep0_toggle_i;
    state_r <= state_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// FIFO write gate

// Registered to keep every output on a flop, at the cost of one cycle of latency
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    fifo_wr_o <= 1'b0;
    fifo_wr_data_o <= 16'h0000;
  end else begin
    // R7: writes dropped while locked
    fifo_wr_o <= fifo_wr_i & ~lock_r;
    fifo_wr_data_o <= fifo_wr_data_i;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Handshake requests and interrupt

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    stall_req_o <= 1'b0;
    zlp_req_o <= 1'b0;
    nak_irq_o <= 1'b0;
  end else begin
    // R12: answer STALL
    stall_req_o <= (state_nxt == `UEP_ST_STALL);
    zlp_req_o <= zlp_pend_nxt;
    // R1: mask gates flags
    // R2: masked flags stay set, irq quiet
    // Next mask, so unmasking a pending flag raises the line with the write
    nak_irq_o <= |(nak_flag_nxt & ~nak_mask_nxt);
  end
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave write channel

// Address and data are latched apart, so the master may offer them in either order
always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    aw_got_r <= 1'b0;
    w_got_r <= 1'b0;
    aw_addr_r <= 5'h00;
    w_data_r <= 32'h00000000;
    w_strb_r <= 4'h0;
    s_axi_awready_o <= 1'b0;
    s_axi_wready_o <= 1'b0;
    s_axi_bvalid_o <= 1'b0;
    s_axi_bresp_o <= `UEP_RESP_OKAY;
  end else begin
    if (aw_take) begin
      aw_addr_r <= s_axi_awaddr_i;
    end
    if (w_take) begin
      w_data_r <= s_axi_wdata_i;
      w_strb_r <= s_axi_wstrb_i;
    end
    if (wr_do) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= resp_for(wr_addr);
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      aw_got_r <= aw_have;
      w_got_r <= w_have;
      if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      // Ready only while a slot is free and no response is pending
      s_axi_awready_o <= ~aw_have & ~(s_axi_bvalid_o & ~s_axi_bready_i);
      s_axi_wready_o <= ~w_have & ~(s_axi_bvalid_o & ~s_axi_bready_i);
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Bus slave read channel

reg [31:0] rd_word;

always @* begin
  rd_word = 32'h00000000;
  case (s_axi_araddr_i[4:2])
    3'h0: begin
      rd_word[`UEP_EP_HI:`UEP_EP_LO] = nak_flag_r;
    end
    3'h1: begin
      rd_word[`UEP_EP_HI:`UEP_EP_LO] = nak_mask_r;
    end
    3'h2: begin
      rd_word[`UEP_MSZ_PKT_HI:0] = max_pkt_r;
      rd_word[`UEP_MSZ_DSET] = dset_r;
      rd_word[`UEP_MSZ_ZLP] = zlp_pend_r;
    end
    3'h3: begin
      rd_word[`UEP_STS_STATE_LO+2:`UEP_STS_STATE_LO] = state_r;
      rd_word[`UEP_STS_TOG_LO+1:`UEP_STS_TOG_LO] = tog_r;
      rd_word[`UEP_STS_LOCK] = lock_r;
    end
    default: begin
      rd_word = 32'h00000000;
    end
  endcase
end

always @(posedge clk_sys_i or negedge rst_n_i) begin
  if (!rst_n_i) begin
    s_axi_arready_o <= 1'b0;
    s_axi_rvalid_o <= 1'b0;
    s_axi_rdata_o <= 32'h00000000;
    s_axi_rresp_o <= `UEP_RESP_OKAY;
  end else begin
    if (rd_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_word;
      s_axi_rresp_o <= resp_for(s_axi_araddr_i);
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end else begin
      // Held low until the data is taken, so one read at most is under way
      s_axi_arready_o <= 1'b1;
    end
  end
end

endmodule // uep_ep0_status

// file: uep_ep0_status_props.sv
`timescale 1ns/1ps
module uep_ep0_status_props (
  // Clock, reset and inputs
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [7:1] nak_sent_i,
  input wire setup_token_i,
  input wire zlp_sent_i,
  input wire status_nak_i,
  input wire rx_crc_err_i,
  input wire tx_timeout_i,
  input wire over_len_read_i,
  input wire fifo_wr_i,
  input wire [15:0] fifo_wr_data_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_rready_i,
  // Outputs
  input wire s_axi_bvalid_o,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire fifo_wr_o,
  input wire [15:0] fifo_wr_data_o,
  input wire stall_req_o,
  input wire zlp_req_o,
  input wire nak_irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Unmasking a pending flag also counts as a cause: it lands with the write response
  a_irq_cause: assert property ($rose(nak_irq_o) |-> $past(|nak_sent_i) || $rose(s_axi_bvalid_o))
    else $error("interrupt rose without a cause");
  a_fifo_pass: assert property (fifo_wr_o |-> $past(fifo_wr_i) && fifo_wr_data_o == $past(fifo_wr_data_i))
    else $error("fifo write not from cpu");
  a_fifo_lock: assert property (setup_token_i ##1 fifo_wr_i |=> !fifo_wr_o)
    else $error("fifo write passed while locked");
  a_stall_set: assert property (over_len_read_i |=> stall_req_o)
    else $error("stall not requested");
  a_stall_leave: assert property ($fell(stall_req_o) |-> $past(setup_token_i || rx_crc_err_i || status_nak_i
    || tx_timeout_i))
    else $error("stall left without event");
  a_zlp_clear: assert property ($fell(zlp_req_o) |-> $past(zlp_sent_i))
    else $error("zero-length pending cleared early");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read not answered");
  a_read_done: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read data held too long");
endmodule // uep_ep0_status_props
bind uep_ep0_status uep_ep0_status_props i_uep_ep0_status_props (.*);

// file: uep_host_model.sv
`timescale 1ns/1ps
module uep_host_model (
  // Clock
  input wire clk_sys_i,
  // Packet engine events
  output wire [7:1] nak_sent_o,
  output wire setup_token_o,
  output wire zlp_sent_o,
  output wire status_nak_o,
  output wire rx_crc_err_o,
  output wire tx_timeout_o,
  output wire over_len_read_o,
  // Endpoint 0 levels
  output reg [1:0] ep0_toggle_o = 2'h0,
  output reg fifo_has_data_o = 1'b0
);
  reg [12:0] ev_r = 13'h0000;
  assign {nak_sent_o, setup_token_o, zlp_sent_o, status_nak_o, rx_crc_err_o, tx_timeout_o, over_len_read_o} = ev_r;
  // Events last exactly one cycle, as the packet engine issues them
  task pulse(input [12:0] ev);
    begin
      @(posedge clk_sys_i);
      ev_r <= ev;
      @(posedge clk_sys_i);
      ev_r <= 13'h0000;
    end
  endtask
  task lvl(input [1:0] t, input h);
    begin
      @(posedge clk_sys_i);
      ep0_toggle_o <= t;
      fifo_has_data_o <= h;
    end
  endtask
endmodule // uep_host_model

// file: test_uep_ep0_status.sv
`timescale 1ns/1ps
module test_uep_ep0_status;
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [4:0] awaddr = 5'h00, araddr = 5'h00;
  reg [31:0] wdata = 32'h0;
  reg awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, fwr = 0;
  reg [15:0] fdata = 16'hA5C3;
  reg [3:0] wstrb = 4'hF;
  wire awr, wrdy, bv, arr, rv, fwr_o, stall, zlp, irq, stok, zsent, snak, crc, tmo, ovl, hasd;
  wire [1:0] bresp, rresp, tog;
  wire [31:0] rdata;
  wire [15:0] fdata_o;
  wire [7:1] nak;
  integer bad_count = 0, tests_run = 0, cyc = 0, i;
  reg [31:0] d;
  reg [1:0] r;
  reg [70:0] rows [0:5];
  reg [44:0] evs [0:6];
  always #4 clk_sys_i = ~clk_sys_i;
  uep_host_model i_uep_host_model (.clk_sys_i(clk_sys_i), .nak_sent_o(nak), .setup_token_o(stok), .zlp_sent_o(zsent),
    .status_nak_o(snak), .rx_crc_err_o(crc), .tx_timeout_o(tmo), .over_len_read_o(ovl), .ep0_toggle_o(tog),
    .fifo_has_data_o(hasd));
  uep_ep0_status i_uep_ep0_status (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .nak_sent_i(nak),
    .setup_token_i(stok), .zlp_sent_i(zsent), .status_nak_i(snak), .rx_crc_err_i(crc), .tx_timeout_i(tmo),
    .over_len_read_i(ovl), .ep0_toggle_i(tog), .fifo_has_data_i(hasd), .fifo_wr_i(fwr), .fifo_wr_data_i(fdata),
    .fifo_wr_o(fwr_o), .fifo_wr_data_o(fdata_o), .stall_req_o(stall), .zlp_req_o(zlp), .nak_irq_o(irq));
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (bad_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task tick;
    @(posedge clk_sys_i);
  endtask
  task wr(input [4:0] a, input [31:0] v, output [1:0] rsp);
    begin: wl
      tick;
      awaddr <= a;
      wdata <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      forever begin
        tick;
        if (awv && awr) awv <= 1'b0;
        if (wv && wrdy) wv <= 1'b0;
        if (bv) begin
          rsp = bresp;
          bready <= 1'b0;
          disable wl;
        end
      end
    end
  endtask
  task rd(input [4:0] a, output [31:0] v, output [1:0] rsp);
    begin: rl
      tick;
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      forever begin
        tick;
        if (arv && arr) arv <= 1'b0;
        if (rv) begin
          v = rdata;
          rsp = rresp;
          rready <= 1'b0;
          disable rl;
        end
      end
    end
  endtask
  task fifo_try(input [31:0] e);
    begin
      tick;
      fwr <= 1'b1;
      tick;
      fwr <= 1'b0;
      tick;
      chk(fwr_o, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Run is under two hundred cycles; the ceiling only catches a hung handshake
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      report_and_stop;
    end
  end
  initial begin
    rows[0] = {5'h04, 32'hFFFFFFFF, 32'h000000FE, 2'h0};
    rows[1] = {5'h08, 32'hFFFFFFFF, 32'h0000007F, 2'h0};
    rows[2] = {5'h0C, 32'hFFFFFFFF, 32'h00000000, 2'h0};
    rows[3] = {5'h10, 32'h00000000, 32'h00000000, 2'h0};
    rows[4] = {5'h14, 32'h00000005, 32'h00000000, 2'h3};
    rows[5] = {5'h04, 32'h00000000, 32'h00000000, 2'h0};
    evs[0] = {13'h0008, 32'h00001200};
    evs[1] = {13'h0020, 32'h00009000};
    evs[2] = {13'h0004, 32'h00009400};
    evs[3] = {13'h0020, 32'h00009000};
    evs[4] = {13'h0002, 32'h00009400};
    evs[5] = {13'h0001, 32'h00009600};
    evs[6] = {13'h0020, 32'h00009000};
    repeat (8) tick;
    rst_n_i <= 1'b1;
    for (i = 0; i < 5; i = i + 1) begin
      rd(5'(i * 4), d, r);
      chk(d, 32'h0);
    end
    for (i = 0; i < 6; i = i + 1) begin
      wr(rows[i][70:66], rows[i][65:34], r);
      chk(r, rows[i][1:0]);
      rd(rows[i][70:66], d, r);
      chk(d, rows[i][33:2]);
      chk(r, rows[i][1:0]);
    end
    i_uep_host_model.pulse(13'h0100);
    tick;
    chk(irq, 1);
    rd(5'h00, d, r);
    chk(d, 32'h8);
    rd(5'h00, d, r);
    chk({d[7:1], irq}, 0);
    wr(5'h04, 32'h8, r);
    i_uep_host_model.pulse(13'h0100);
    tick;
    chk(irq, 0);
    rd(5'h00, d, r);
    chk(d, 32'h8);
    i_uep_host_model.lvl(2'h1, 1'b1);
    for (i = 0; i < 7; i = i + 1) begin
      i_uep_host_model.pulse(evs[i][44:32]);
      rd(5'h0C, d, r);
      chk(d, evs[i][31:0]);
    end
    fifo_try(0);
    rd(5'h08, d, r);
    chk(d, 32'h107F);
    wr(5'h10, 32'h2, r);
    rd(5'h0C, d, r);
    chk(d, 32'h1000);
    fifo_try(1);
    chk(fdata_o, fdata);
    wr(5'h10, 32'h1, r);
    rd(5'h08, d, r);
    chk(d, 32'h907F);
    chk(zlp, 1);
    i_uep_host_model.pulse(13'h0010);
    tick;
    chk(zlp, 0);
    // Unmasking a flag that is already pending raises the line
    i_uep_host_model.pulse(13'h0100);
    wr(5'h04, 32'h0, r);
    tick;
    chk(irq, 1);
    rd(5'h00, d, r);
    chk(d, 32'h8);
    // A setup token in the middle of a FIFO burst locks out the rest
    fwr <= 1'b1;
    i_uep_host_model.pulse(13'h0020);
    tick;
    fwr <= 1'b0;
    tick;
    chk(fwr_o, 0);
    rd(5'h0C, d, r);
    chk(d, 32'h9000);
    // Reset in mid-run clears every field; live levels return on the next edge
    rst_n_i <= 1'b0;
    tick;
    chk({stall, zlp, irq, fwr_o, bv, rv}, 0);
    rst_n_i <= 1'b1;
    rd(5'h0C, d, r);
    chk(d, 32'h1000);
    wstrb <= 4'hE;
    wr(5'h08, 32'h7F, r);
    wstrb <= 4'hF;
    chk(r, 2'h0);
    rd(5'h08, d, r);
    chk(d, 32'h1000);
    rd(5'h04, d, r);
    chk(d, 32'h0);
    report_and_stop;
  end
endmodule // test_uep_ep0_status
